// *** logic/fast_osc_params.svh ***
/*
  constants of the fast oscillator control block: register offsets,
  field positions, reset values and stabilization wait counts.
  assumes it is included by its bare name wherever it is needed.
*/
`ifndef FAST_OSC_PARAMS_SVH
`define FAST_OSC_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_SOURCE         8'h04
`define OFS_WAIT           8'h08
`define OFS_CLKOUT         8'h0C
`define OFS_STATUS         8'h10

// ==========================================================
// control register fields
`define BIT_INT_ENABLE     0
`define BIT_RES_ENABLE     1
`define BIT_SLOW_ENABLE    2

// source register fields
`define POS_SYS_SRC        0
`define POS_FREQ_SEL       4
`define BIT_SLOW_SELECT    8

// wait register fields
`define POS_INT_WAIT       0
`define POS_RES_WAIT       4

// clock output register fields, channel b sits 8 bits higher
`define BIT_OUT_ENABLE     0
`define POS_OUT_SRC        1
`define POS_OUT_DIV        4
`define OUT_CHAN_STRIDE    8

// status register fields
`define BIT_INT_STABLE     0
`define BIT_RES_STABLE     1
`define BIT_SLOW_LEVEL     2
`define BIT_CPU_RUN        3

// ==========================================================
// reset values
`define RST_INT_ENABLE     1'b1
`define RST_RES_ENABLE     1'b0
`define RST_SLOW_ENABLE    1'b0
`define RST_SLOW_SELECT    1'b1
`define RST_FIELD2         2'h0

// ==========================================================
// encodings
`define SRC_FAST_INT       2'h0
`define SRC_SLOW           2'h1
`define SRC_FAST_RES       2'h2
`define SRC_RESERVED       2'h3
`define FREQ_RESERVED      2'h3
`define OUT_SRC_INT        2'h0
`define OUT_SRC_RES        2'h1
`define OUT_SRC_SLOW       2'h2

// ==========================================================
// stabilization waits in oscillator cycles at field value 0
`define INT_WAIT_MAX       11'h040
`define RES_WAIT_MAX       11'h400

`endif

// *** logic/fast_osc_pkg.sv ***
/*
  types shared by the fast oscillator control files.
  assumes fast_osc_params.svh carries the numeric constants.
*/
package fast_osc_pkg;
  typedef logic [1:0]  field2_type;
  typedef logic [10:0] wait_count_type;
  typedef logic [31:0] word_type;
endpackage

// *** logic/osc_stab_wait.sv ***
/*
  stabilization wait counter for one oscillator.
  assumes osc_edge is a one-cycle pulse per oscillator cycle, already
  synchronised to mclk, and wait_cycles is steady while counting.
*/
`timescale 1ns/1ps
module osc_stab_wait
  import fast_osc_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire logic           run,
  input  wire logic           osc_edge,
  input  wire wait_count_type wait_cycles,
  output logic                stable_reg
);
  wait_count_type count_reg;

  // ==========================================================
  // count oscillator cycles, restart whenever the oscillator halts
  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      count_reg <= '0;
    end else if (osc_edge && !stable_reg) begin
      count_reg <= count_reg + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      stable_reg <= 1'b0;
    end else if (count_reg >= wait_cycles) begin
      stable_reg <= 1'b1;
    end
  end
endmodule // osc_stab_wait

// *** logic/fast_osc_control.sv ***
/*
  fast oscillator control: enables, sleep stop, frequency select,
  stabilization waits, system clock source, two divided clock outputs,
  and an avalon-mm register slave with waitrequest.
  assumes the oscillator outputs arrive asynchronous to mclk and each
  runs below half the mclk rate; sleep_mode comes from mclk logic.
*/
// What this block does
// - internal oscillator frequency from a 2-bit select, 0=2M 1=1M 2=500k, resets 0.
// - internal oscillator runs while its enable is 1, halts at 0.
// - internal oscillator halts in sleep regardless of its enable.
// - internal oscillator enable resets to 1 so the system starts on it.
// - internal clock withheld after start until its wait has elapsed.
// - internal wait select 3/2/1/0 gives 8/16/32/64 cycles, resets 0.
// - cpu starts only after internal oscillator finishes its 64-cycle wait.
// - resonator oscillator runs while its enable is 1, halts at 0.
// - resonator oscillator halts in sleep regardless of its enable.
// - resonator oscillator enable resets to 0, oscillator halted.
// - resonator clock withheld after start until its wait has elapsed.
// - resonator wait select 3/2/1/0 gives 128/256/512/1024 cycles, resets 0.
// - two clock outputs, each a divided fast or slow clock.
// - system clock is internal after reset, software may switch sources.
// - slow clock taken from crystal or internal slow oscillator by select.
`timescale 1ns/1ps
`include "fast_osc_params.svh"
module fast_osc_control
  import fast_osc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_mode,
  input  wire logic        fast_internal_osc,
  input  wire logic        fast_resonator_osc,
  input  wire logic        slow_crystal_osc,
  input  wire logic        slow_internal_osc,
  output logic             fast_internal_run_reg,
  output field2_type       fast_internal_freq_sel_reg,
  output logic             fast_resonator_run_reg,
  output logic             slow_run_reg,
  output logic             slow_select_reg,
  output field2_type       sys_clock_src_reg,
  output logic             sys_clock_supply_reg,
  output logic             cpu_run_reg,
  output logic             clock_out_a,
  output logic             clock_out_b
);
  // ==========================================================
  // software state
  logic           fast_internal_enable_reg;
  logic           fast_resonator_enable_reg;
  logic           slow_enable_reg;
  field2_type     fast_internal_wait_sel_reg;
  field2_type     fast_resonator_wait_sel_reg;
  logic [1:0]     out_enable_reg;
  field2_type     out_src_reg [2];
  field2_type     out_div_reg [2];
  logic           sleep_prev_reg;
  logic           int_stable;
  logic           res_stable;
  logic           slow_clock_reg;
  logic           slow_prev_reg;
  logic           slow_edge;
  logic [3:0]     osc_pin;
  logic [3:0]     sync1_reg;
  logic [3:0]     sync2_reg;
  logic [3:0]     sync3_reg;
  logic [3:0]     osc_edge;
  logic [1:0]     out_reg;
  logic           write_hit;
  logic           sleep_exit;
  word_type       read_next;
  wait_count_type int_wait_cycles;
  wait_count_type res_wait_cycles;

  assign write_hit  = avs_write && !avs_waitrequest;
  assign sleep_exit = sleep_prev_reg && !sleep_mode;

  // ==========================================================
  // avalon slave: one wait cycle, then the access completes
  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_comb begin
    read_next = '0;
    case (avs_address)
      `OFS_CONTROL: begin
        read_next[`BIT_INT_ENABLE]  = fast_internal_enable_reg;
        read_next[`BIT_RES_ENABLE]  = fast_resonator_enable_reg;
        read_next[`BIT_SLOW_ENABLE] = slow_enable_reg;
      end
      `OFS_SOURCE: begin
        read_next[`POS_SYS_SRC+:2]  = sys_clock_src_reg;
        read_next[`POS_FREQ_SEL+:2] = fast_internal_freq_sel_reg;
        read_next[`BIT_SLOW_SELECT] = slow_select_reg;
      end
      `OFS_WAIT: begin
        read_next[`POS_INT_WAIT+:2] = fast_internal_wait_sel_reg;
        read_next[`POS_RES_WAIT+:2] = fast_resonator_wait_sel_reg;
      end
      `OFS_CLKOUT: begin
        read_next[`BIT_OUT_ENABLE] = out_enable_reg[0];
        read_next[`POS_OUT_SRC+:2] = out_src_reg[0];
        read_next[`POS_OUT_DIV+:2] = out_div_reg[0];
        read_next[`OUT_CHAN_STRIDE+`BIT_OUT_ENABLE] = out_enable_reg[1];
        read_next[`OUT_CHAN_STRIDE+`POS_OUT_SRC+:2] = out_src_reg[1];
        read_next[`OUT_CHAN_STRIDE+`POS_OUT_DIV+:2] = out_div_reg[1];
      end
      `OFS_STATUS: begin
        read_next[`BIT_INT_STABLE] = int_stable;
        read_next[`BIT_RES_STABLE] = res_stable;
        read_next[`BIT_SLOW_LEVEL] = slow_clock_reg;
        read_next[`BIT_CPU_RUN]    = cpu_run_reg;
      end
      default: begin
        read_next = '0;
      end
    endcase
  end

  // read data stand from the edge that drops waitrequest
  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_waitrequest && avs_read) begin
      avs_readdata <= read_next;
    end
  end

  // ==========================================================
  // enables; leaving sleep forces the internal oscillator on
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_internal_enable_reg  <= `RST_INT_ENABLE;
      fast_resonator_enable_reg <= `RST_RES_ENABLE;
      slow_enable_reg           <= `RST_SLOW_ENABLE;
    end else begin
      if (write_hit && avs_address == `OFS_CONTROL && avs_byteenable[0]) begin
        fast_internal_enable_reg  <= avs_writedata[`BIT_INT_ENABLE];
        fast_resonator_enable_reg <= avs_writedata[`BIT_RES_ENABLE];
        slow_enable_reg           <= avs_writedata[`BIT_SLOW_ENABLE];
      end
      if (sleep_exit) begin
        fast_internal_enable_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sleep_prev_reg <= 1'b0;
    end else begin
      sleep_prev_reg <= sleep_mode;
    end
  end

  // ==========================================================
  // source register; reserved codes are not stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_clock_src_reg          <= `SRC_FAST_INT;
      fast_internal_freq_sel_reg <= `RST_FIELD2;
      slow_select_reg            <= `RST_SLOW_SELECT;
    end else begin
      if (write_hit && avs_address == `OFS_SOURCE && avs_byteenable[0]) begin
        if (avs_writedata[`POS_SYS_SRC+:2] != `SRC_RESERVED) begin
          sys_clock_src_reg <= avs_writedata[`POS_SYS_SRC+:2];
        end
        if (avs_writedata[`POS_FREQ_SEL+:2] != `FREQ_RESERVED) begin
          fast_internal_freq_sel_reg <= avs_writedata[`POS_FREQ_SEL+:2];
        end
      end
      if (write_hit && avs_address == `OFS_SOURCE && avs_byteenable[1]) begin
        slow_select_reg <= avs_writedata[`BIT_SLOW_SELECT];
      end
      if (sleep_exit) begin
        sys_clock_src_reg <= `SRC_FAST_INT;
      end
    end
  end

  // wait selects and the wait cycle counts they select
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_internal_wait_sel_reg  <= `RST_FIELD2;
      fast_resonator_wait_sel_reg <= `RST_FIELD2;
    end else if (write_hit && avs_address == `OFS_WAIT && avs_byteenable[0]) begin
      fast_internal_wait_sel_reg  <= avs_writedata[`POS_INT_WAIT+:2];
      fast_resonator_wait_sel_reg <= avs_writedata[`POS_RES_WAIT+:2];
    end
  end

  assign int_wait_cycles = `INT_WAIT_MAX >> fast_internal_wait_sel_reg;
  assign res_wait_cycles = `RES_WAIT_MAX >> fast_resonator_wait_sel_reg;

  // ==========================================================
  // oscillator run outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_internal_run_reg  <= 1'b0;
      fast_resonator_run_reg <= 1'b0;
      slow_run_reg           <= 1'b0;
    end else begin
      fast_internal_run_reg  <= fast_internal_enable_reg && !sleep_mode;
      fast_resonator_run_reg <= fast_resonator_enable_reg && !sleep_mode;
      slow_run_reg           <= slow_enable_reg;
    end
  end

  // ==========================================================
  // oscillator pins: two-stage synchroniser, then edge detect
  assign osc_pin = {slow_internal_osc, slow_crystal_osc,
                    fast_resonator_osc, fast_internal_osc};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (reset) begin
          sync1_reg[i] <= 1'b0;
          sync2_reg[i] <= 1'b0;
          sync3_reg[i] <= 1'b0;
        end else begin
          sync1_reg[i] <= osc_pin[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
        end
      end
      assign osc_edge[i] = sync2_reg[i] && !sync3_reg[i];
    end
  endgenerate

  // slow clock from the selected slow oscillator
  always_ff @(posedge mclk) begin
    if (reset) begin
      slow_clock_reg <= 1'b0;
      slow_prev_reg  <= 1'b0;
    end else begin
      slow_clock_reg <= slow_select_reg ? sync2_reg[3] : sync2_reg[2];
      slow_prev_reg  <= slow_clock_reg;
    end
  end
  assign slow_edge = slow_clock_reg && !slow_prev_reg && slow_run_reg;

  // ==========================================================
  // stabilization waits
  osc_stab_wait u_int_wait (
    .mclk        (mclk),
    .reset       (reset),
    .run         (fast_internal_run_reg),
    .osc_edge    (osc_edge[0]),
    .wait_cycles (int_wait_cycles),
    .stable_reg  (int_stable)
  );

  osc_stab_wait u_res_wait (
    .mclk        (mclk),
    .reset       (reset),
    .run         (fast_resonator_run_reg),
    .osc_edge    (osc_edge[1]),
    .wait_cycles (res_wait_cycles),
    .stable_reg  (res_stable)
  );

  // a fast clock reaches the system only once its source is stable; the slow clock once it runs
  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_clock_supply_reg <= 1'b0;
    end else begin
      case (sys_clock_src_reg)
        `SRC_FAST_INT: sys_clock_supply_reg <= int_stable;
        `SRC_FAST_RES: sys_clock_supply_reg <= res_stable;
        `SRC_SLOW:     sys_clock_supply_reg <= slow_run_reg;
        default:       sys_clock_supply_reg <= 1'b0;
      endcase
    end
  end

  // cpu start after the first internal wait; held afterwards
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_run_reg <= 1'b0;
    end else if (int_stable) begin
      cpu_run_reg <= 1'b1;
    end
  end

  // ==========================================================
  // divided clock outputs
  generate
    for (genvar c = 0; c < 2; c++) begin : g_out
      logic [6:0] div_count_reg;
      logic       src_edge;
      localparam int BASE = c * `OUT_CHAN_STRIDE;

      always_ff @(posedge mclk) begin
        if (reset) begin
          out_enable_reg[c] <= 1'b0;
          out_src_reg[c]    <= `OUT_SRC_INT;
          out_div_reg[c]    <= `RST_FIELD2;
        end else if (write_hit && avs_address == `OFS_CLKOUT &&
                     avs_byteenable[c]) begin
          out_enable_reg[c] <= avs_writedata[BASE+`BIT_OUT_ENABLE];
          out_src_reg[c]    <= avs_writedata[BASE+`POS_OUT_SRC+:2];
          out_div_reg[c]    <= avs_writedata[BASE+`POS_OUT_DIV+:2];
        end
      end

      always_comb begin
        case (out_src_reg[c])
          `OUT_SRC_INT:  src_edge = osc_edge[0] && int_stable;
          `OUT_SRC_RES:  src_edge = osc_edge[1] && res_stable;
          `OUT_SRC_SLOW: src_edge = slow_edge;
          default:       src_edge = 1'b0;
        endcase
      end

      // half period of 1, 4, 16 or 64 source cycles
      always_ff @(posedge mclk) begin
        if (reset || !out_enable_reg[c]) begin
          div_count_reg <= '0;
          out_reg[c]    <= 1'b0;
        end else if (src_edge) begin
          if (div_count_reg >= (7'h01 << {out_div_reg[c], 1'b0}) - 7'h01) begin
            div_count_reg <= '0;
            out_reg[c]    <= !out_reg[c];
          end else begin
            div_count_reg <= div_count_reg + 7'h01;
          end
        end
      end
    end
  endgenerate

  assign clock_out_a = out_reg[0];
  assign clock_out_b = out_reg[1];

  // ==========================================================
  // checks
  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_int_start;
    $rose(fast_internal_run_reg);
  endsequence

  property p_reset_state;
    @(posedge mclk) $past(reset) && !reset |-> fast_internal_enable_reg &&
      !fast_resonator_enable_reg && fast_internal_freq_sel_reg == 2'h0 &&
      fast_internal_wait_sel_reg == 2'h0 && fast_resonator_wait_sel_reg == 2'h0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset wrong");

  property p_sleep_halts;
    @(posedge mclk) disable iff (reset)
      sleep_mode |=> !fast_internal_run_reg && !fast_resonator_run_reg;
  endproperty
  a_sleep_halts: assert property (p_sleep_halts)
    else $error("oscillator running in sleep");

  property p_int_run;
    @(posedge mclk) disable iff (reset)
      (fast_internal_enable_reg && !sleep_mode) [*2] |-> fast_internal_run_reg;
  endproperty
  a_int_run: assert property (p_int_run)
    else $error("internal oscillator not running");

  property p_res_run;
    @(posedge mclk) disable iff (reset)
      !fast_resonator_enable_reg [*2] |-> !fast_resonator_run_reg;
  endproperty
  a_res_run: assert property (p_res_run)
    else $error("resonator running while disabled");

  property p_int_withheld;
    @(posedge mclk) disable iff (reset)
      s_int_start |-> !int_stable [*8];
  endproperty
  a_int_withheld: assert property (p_int_withheld)
    else $error("internal clock supplied too early");

  property p_res_withheld;
    @(posedge mclk) disable iff (reset)
      $rose(fast_resonator_run_reg) |-> !res_stable [*8];
  endproperty
  a_res_withheld: assert property (p_res_withheld)
    else $error("resonator clock supplied too early");

  property p_cpu_after_wait;
    @(posedge mclk) disable iff (reset)
      $rose(cpu_run_reg) |-> $past(int_stable);
  endproperty
  a_cpu_after_wait: assert property (p_cpu_after_wait)
    else $error("cpu started before internal wait");

  property p_supply_needs_stable;
    @(posedge mclk) disable iff (reset)
      sys_clock_supply_reg && sys_clock_src_reg == `SRC_FAST_RES &&
      $stable(sys_clock_src_reg) |-> $past(res_stable);
  endproperty
  a_supply_needs_stable: assert property (p_supply_needs_stable)
    else $error("system clock supplied from unstable source");

  property p_bus_answer;
    @(posedge mclk) disable iff (reset)
      s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer timing wrong");

  property p_out_idle;
    @(posedge mclk) disable iff (reset)
      !out_enable_reg[0] |=> !clock_out_a;
  endproperty
  a_out_idle: assert property (p_out_idle)
    else $error("clock output active while disabled");
endmodule // fast_osc_control

// *** dv/testbench.sv ***
/*
  self-checking bench for fast_osc_control: bus tasks, oscillator stimulus
  and one task per scenario.
  assumes the design files under logic/ are compiled first.
*/
`timescale 1ns/1ps
`include "fast_osc_params.svh"
module testbench;
  import fast_osc_pkg::*;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       avs_address = 8'h00;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0000_0000;
  logic [3:0]       avs_byteenable = 4'hf;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             sleep_mode = 1'b0;
  logic             fast_internal_osc = 1'b0;
  logic             fast_resonator_osc = 1'b0;
  logic             slow_crystal_osc = 1'b0;
  logic             slow_internal_osc = 1'b0;
  logic             fast_internal_run_reg, fast_resonator_run_reg;
  logic             slow_run_reg, slow_select_reg, sys_clock_supply_reg;
  logic             cpu_run_reg, clock_out_a, clock_out_b;
  field2_type       fast_internal_freq_sel_reg, sys_clock_src_reg;
  int               err_count = 0;
  int               total_checks = 0;
  int               int_rises = 0;
  int               res_rises = 0;
  int               int_div = 0;
  int               res_div = 0;
  logic [31:0]      rd;

  fast_osc_control dut (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_mode(sleep_mode), .fast_internal_osc(fast_internal_osc),
    .fast_resonator_osc(fast_resonator_osc),
    .slow_crystal_osc(slow_crystal_osc),
    .slow_internal_osc(slow_internal_osc),
    .fast_internal_run_reg(fast_internal_run_reg),
    .fast_internal_freq_sel_reg(fast_internal_freq_sel_reg),
    .fast_resonator_run_reg(fast_resonator_run_reg),
    .slow_run_reg(slow_run_reg), .slow_select_reg(slow_select_reg),
    .sys_clock_src_reg(sys_clock_src_reg),
    .sys_clock_supply_reg(sys_clock_supply_reg), .cpu_run_reg(cpu_run_reg),
    .clock_out_a(clock_out_a), .clock_out_b(clock_out_b));

  always #20 mclk = ~mclk;

  // ==========================================================
  // oscillators: half period 3 mclk, stopped while not running
  always @(posedge mclk) begin
    if (reset || fast_internal_run_reg !== 1'b1) begin
      int_div <= 0;
      fast_internal_osc <= 1'b0;
    end else if (int_div == 2) begin
      int_div <= 0;
      fast_internal_osc <= ~fast_internal_osc;
      if (!fast_internal_osc) int_rises <= int_rises + 1;
    end else int_div <= int_div + 1;
  end
  always @(posedge mclk) begin
    if (reset || fast_resonator_run_reg !== 1'b1) begin
      res_div <= 0;
      fast_resonator_osc <= 1'b0;
    end else if (res_div == 2) begin
      res_div <= 0;
      fast_resonator_osc <= ~fast_resonator_osc;
      if (!fast_resonator_osc) res_rises <= res_rises + 1;
    end else res_div <= res_div + 1;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ==========================================================
  // avalon-mm master
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 50) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // wait for supply, then compare oscillator rises since base
  task automatic wait_supply(input bit res, input int base, input int n);
    int i;
    int cnt;
    for (i = 0; i < 20000 && sys_clock_supply_reg !== 1'b1; i++)
      @(posedge mclk);
    if (i >= 20000) begin
      err_count++;
      complete_run();
    end
    cnt = (res ? res_rises : int_rises) - base;
    check({31'h0, cnt >= n && cnt <= n + 1}, 32'h0000_0001);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wait_supply(1'b0, 0, 64);
    check({31'h0, cpu_run_reg}, 32'h0000_0001);
    bus(1'b0, `OFS_CONTROL, 0, rd);
    check(rd, 32'h0000_0001);
    bus(1'b0, `OFS_SOURCE, 0, rd);
    check(rd, 32'h0000_0100);
    bus(1'b0, `OFS_WAIT, 0, rd);
    check(rd, 32'h0000_0000);
    bus(1'b0, 8'h20, 0, rd);
    check(rd, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_int_wait();
    int base;
    wr(`OFS_WAIT, 32'h0000_0003);
    wr(`OFS_CONTROL, 32'h0000_0000);
    cycles(4);
    check({31'h0, fast_internal_run_reg}, 32'h0000_0000);
    check({31'h0, sys_clock_supply_reg}, 32'h0000_0000);
    base = int_rises;
    wr(`OFS_CONTROL, 32'h0000_0001);
    wait_supply(1'b0, base, 8);
    $display("test internal wait done");
  endtask

  task automatic t_res_wait();
    int base;
    wr(`OFS_WAIT, 32'h0000_0033);
    wr(`OFS_SOURCE, 32'h0000_0102);
    cycles(2);
    check({30'h0, sys_clock_src_reg}, 32'h0000_0002);
    check({31'h0, sys_clock_supply_reg}, 32'h0000_0000);
    base = res_rises;
    wr(`OFS_CONTROL, 32'h0000_0003);
    wait_supply(1'b1, base, 128);
    check({31'h0, fast_resonator_run_reg}, 32'h0000_0001);
    $display("test resonator wait done");
  endtask

  task automatic t_sleep();
    wr(`OFS_CONTROL, 32'h0000_0002);
    @(posedge mclk);
    sleep_mode <= 1'b1;
    cycles(3);
    check({31'h0, fast_internal_run_reg}, 32'h0000_0000);
    check({31'h0, fast_resonator_run_reg}, 32'h0000_0000);
    sleep_mode <= 1'b0;
    cycles(3);
    check({30'h0, sys_clock_src_reg}, 32'h0000_0000);
    check({31'h0, fast_resonator_run_reg}, 32'h0000_0001);
    bus(1'b0, `OFS_CONTROL, 0, rd);
    check(rd, 32'h0000_0003);
    $display("test sleep done");
  endtask

  task automatic t_fields();
    for (int v = 0; v < 3; v++) begin
      wr(`OFS_SOURCE, 32'h0000_0100 | (v << 4));
      cycles(1);
      check({30'h0, fast_internal_freq_sel_reg}, v);
    end
    wr(`OFS_SOURCE, 32'h0000_0130);
    cycles(1);
    check({30'h0, fast_internal_freq_sel_reg}, 32'h0000_0002);
    wr(`OFS_SOURCE, 32'h0000_0020);
    cycles(1);
    check({31'h0, slow_select_reg}, 32'h0000_0000);
    $display("test fields done");
  endtask

  task automatic t_clkout();
    int toggles;
    logic last;
    check({31'h0, clock_out_a}, 32'h0000_0000);
    wr(`OFS_CLKOUT, 32'h0000_0001);
    last = clock_out_a;
    toggles = 0;
    repeat (100) begin
      @(posedge mclk);
      if (clock_out_a !== last) toggles++;
      last = clock_out_a;
    end
    check({31'h0, toggles > 4}, 32'h0000_0001);
    check({31'h0, clock_out_b}, 32'h0000_0000);
    $display("test clock out done");
  endtask

  task automatic t_slow();
    slow_internal_osc <= 1'b1;
    wr(`OFS_CONTROL, 32'h0000_0007);
    wr(`OFS_SOURCE, 32'h0000_0100);
    bus(1'b0, `OFS_STATUS, 0, rd);
    check({29'h0, rd[3:2], rd[0]}, 32'h0000_0007);
    check({31'h0, slow_run_reg}, 32'h0000_0001);
    wr(`OFS_SOURCE, 32'h0000_0000);
    bus(1'b0, `OFS_STATUS, 0, rd);
    check({31'h0, rd[2]}, 32'h0000_0000);
    slow_internal_osc <= 1'b0;
    $display("test slow clock done");
  endtask

  initial begin
    cycles(3);
    reset <= 1'b0;
    t_reset();
    t_int_wait();
    t_res_wait();
    t_sleep();
    t_fields();
    t_clkout();
    t_slow();
    complete_run();
  end
endmodule // testbench
